// ==== hw/asm_status_mode.sv ====
// status and mode registers of the converter serial register bank
//
// Function
// RQ1: 8-bit read-only status, code 000, reset 0x80
// RQ2: status shifts out bit 7 first
// RQ3: ready-pending clears when new result stored
// RQ4: ready-pending sets after data read, before overwrite
// RQ5: ready-pending sets on low power, sync low
// RQ6: serial-out pin also shows end of conversion
// RQ7: error bit follows clamped results with ready
// RQ8: error bit sets on calibration faults
// RQ9: reference-missing bit tracks low reference, clamps ones
// RQ10: parity bit shows odd ones in data
// RQ11: host should append status when using parity
// RQ12: append status after data on each read
// RQ13: channel tag is that of held result
// RQ14: 24-bit mode register, code 001, reset 0x080060
// RQ15: mode register transfers bit 23 first
// RQ16: mode write resets filter, sets ready-pending
// RQ17: mode fields placed at documented bit positions
// RQ18: reset sets clock bit 19, rate bits 6,5
// RQ19: select bits pick register; 000 read status
`timescale 1ns/1ps
`include "asm_regs.svh"

module asm_status_mode #(
  parameter int DATA_W = 24
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // serial pins
  input wire logic sclk,
  input wire logic din,
  input wire logic cs_n,
  input wire logic filter_sync_n,
  output logic dout_rdy,
  output logic dout_rdy_oe,
  // converter core
  input wire logic result_valid,
  input wire logic [DATA_W-1:0] result_data,
  input wire logic result_clamped,
  input wire logic [3:0] result_channel,
  input wire logic update_warn,
  input wire logic low_power_entry,
  input wire logic cal_error,
  input wire logic ref_low,
  input wire logic reference_detect_enable,
  // mode controls
  output logic filter_reset,
  output logic [2:0] operating_mode_select,
  output logic append_status_enable,
  output logic [1:0] clock_source_select,
  output logic fast_settle_average_hi,
  output logic fast_settle_average_lo,
  output logic third_order_filter_select,
  output logic parity_check_enable,
  output logic clock_halve_enable,
  output logic single_cycle_settle,
  output logic notch_sixty_hz_enable,
  output logic [9:0] rate_word,
  // status view
  output logic [7:0] converter_status
);

  // ------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [3:0] pins_s;
  logic sclk_s;
  logic din_s;
  logic cs_n_s;
  logic fsync_n_s;
  logic sclk_d_r;
  logic sclk_rise;
  logic sclk_fall;

  asm_pin_sync #(
    .W(4),
    .RST_VAL(4'hF)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin_in({sclk, din, cs_n, filter_sync_n}),
    .pin_sync(pins_s)
  );

  assign sclk_s = pins_s[3];
  assign din_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign fsync_n_s = pins_s[0];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sclk_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // bits in the data phase for a register code and direction
  function automatic logic [5:0] frame_len(input logic [2:0] rs, input logic rd,
                                           input logic app);
    logic [5:0] len;
    len = `ASM_LEN_NONE;
    case (rs)
      `ASM_RS_STATUS: begin
        len = rd ? `ASM_LEN_BYTE : `ASM_LEN_NONE; // RQ19
      end
      `ASM_RS_DATA: begin
        if (rd) begin
          len = app ? `ASM_LEN_WORD_STATUS : `ASM_LEN_WORD; // RQ12
        end
      end
      `ASM_RS_IDENT, `ASM_RS_GPO: begin
        len = `ASM_LEN_BYTE;
      end
      default: begin
        len = `ASM_LEN_WORD;
      end
    endcase
    return len;
  endfunction

  // left-aligned read word, first bit at the top
  function automatic logic [31:0] read_word(input logic [2:0] rs, input logic [7:0] sts,
                                            input logic [23:0] mode, input logic [23:0] dat);
    logic [31:0] w;
    w = 32'h0;
    case (rs)
      `ASM_RS_STATUS: begin
        w = {sts, 24'h0}; // RQ1 RQ2
      end
      `ASM_RS_MODE: begin
        w = {mode, 8'h0}; // RQ15
      end
      `ASM_RS_DATA: begin
        w = {dat, sts}; // RQ12
      end
      default: begin
        w = 32'h0;
      end
    endcase
    return w;
  endfunction

  // ------------------------------------------------------------
  // serial interface
  // ------------------------------------------------------------
  asm_pkg::asm_state_t state_r, state_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [5:0] len_r, len_nxt;
  logic [23:0] rx_r, rx_nxt;
  logic [31:0] tx_r, tx_nxt;
  logic rd_r, rd_nxt;
  logic [2:0] rs_r, rs_nxt;
  logic dout_r, dout_nxt;
  logic oe_r, oe_nxt;
  logic mode_wr;
  logic data_rd_done;
  logic [6:0] cmd;
  logic [31:0] rword;
  logic [23:0] data_r, data_nxt;
  logic [7:0] status_r, status_nxt;
  logic [23:0] mode_r, mode_nxt;

  assign cmd = {rx_r[5:0], din_s};
  assign rword = read_word(cmd[5:3], status_r, mode_r, data_r);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    rd_nxt = rd_r;
    rs_nxt = rs_r;
    dout_nxt = dout_r;
    oe_nxt = ~cs_n_s;
    mode_wr = 1'b0;
    data_rd_done = 1'b0;
    if (cs_n_s) begin
      // deselect aborts any frame in flight
      state_nxt = asm_pkg::ASM_ST_IDLE;
      cnt_nxt = 6'h00;
      dout_nxt = status_r[`ASM_SR_RDY];
    end else begin
      case (state_r)
        asm_pkg::ASM_ST_IDLE: begin
          dout_nxt = status_r[`ASM_SR_RDY]; // RQ6
          if (sclk_rise && !din_s) begin
            state_nxt = asm_pkg::ASM_ST_CMD;
            cnt_nxt = 6'h00;
          end
        end
        asm_pkg::ASM_ST_CMD: begin
          if (sclk_rise) begin
            rx_nxt = {rx_r[22:0], din_s};
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r == `ASM_CMD_BITS - 6'h01) begin
              rd_nxt = cmd[6];
              rs_nxt = cmd[5:3]; // RQ19
              len_nxt = frame_len(cmd[5:3], cmd[6], mode_r[`ASM_MR_APPEND]);
              cnt_nxt = 6'h00;
              if (len_nxt == `ASM_LEN_NONE) begin
                state_nxt = asm_pkg::ASM_ST_IDLE;
              end else begin
                state_nxt = asm_pkg::ASM_ST_DATA;
                if (cmd[6]) begin
                  tx_nxt = rword;
                  dout_nxt = rword[31]; // RQ2 RQ15
                end
              end
            end
          end
        end
        asm_pkg::ASM_ST_DATA: begin
          if (rd_r && sclk_fall) begin
            // bit goes out on the fall so a host sampling on the rise sees the msb first
            tx_nxt = {tx_r[30:0], 1'b0};
            dout_nxt = tx_r[31]; // RQ2 RQ15
          end
          if (sclk_rise) begin
            rx_nxt = {rx_r[22:0], din_s};
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r == len_r - 6'h01) begin
              state_nxt = asm_pkg::ASM_ST_IDLE;
              if (!rd_r && rs_r == `ASM_RS_MODE) begin
                mode_wr = 1'b1; // RQ14
              end
              if (rd_r && rs_r == `ASM_RS_DATA) begin
                data_rd_done = 1'b1; // RQ4
              end
            end
          end
        end
        default: begin
          state_nxt = asm_pkg::ASM_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= asm_pkg::ASM_ST_IDLE;
      cnt_r <= 6'h00;
      len_r <= 6'h00;
      rx_r <= 24'h0;
      tx_r <= 32'h0;
      rd_r <= 1'b0;
      rs_r <= 3'h0;
      dout_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      rd_r <= rd_nxt;
      rs_r <= rs_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ------------------------------------------------------------
  // status register and held result
  // ------------------------------------------------------------
  logic rdy_v;
  logic err_v;
  logic ref_miss_v;
  logic [3:0] chan_v;

  always_comb begin
    rdy_v = status_r[`ASM_SR_RDY];
    err_v = status_r[`ASM_SR_ERR];
    chan_v = status_r[3:0];
    data_nxt = data_r;
    ref_miss_v = reference_detect_enable & ref_low; // RQ9
    if (result_valid) begin
      rdy_v = 1'b0; // RQ3
      err_v = result_clamped | ref_miss_v; // RQ7
      data_nxt = ref_miss_v ? {DATA_W{1'b1}} : result_data; // RQ9
      chan_v = result_channel; // RQ13
    end
    if (cal_error) begin
      err_v = 1'b1; // RQ8
    end
    // set events win over a result arriving in the same cycle
    if (data_rd_done || update_warn) begin
      rdy_v = 1'b1; // RQ4
    end
    if (low_power_entry || !fsync_n_s) begin
      rdy_v = 1'b1; // RQ5
    end
    if (mode_wr) begin
      rdy_v = 1'b1; // RQ16
    end
    status_nxt = {rdy_v, err_v, ref_miss_v,
                  mode_nxt[`ASM_MR_PARITY] & (^data_nxt), chan_v}; // RQ10
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_r <= `ASM_STATUS_RESET; // RQ1
      data_r <= 24'h0;
    end else begin
      status_r <= status_nxt;
      data_r <= data_nxt;
    end
  end

  // ------------------------------------------------------------
  // mode register
  // ------------------------------------------------------------
  logic filt_rst_r, filt_rst_nxt;

  always_comb begin
    mode_nxt = mode_r;
    filt_rst_nxt = 1'b0;
    if (mode_wr) begin
      // bit 14 is held at zero whatever is written
      mode_nxt = {rx_r[22:0], din_s} & `ASM_MODE_WMASK; // RQ17
      filt_rst_nxt = 1'b1; // RQ16
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_r <= `ASM_MODE_RESET; // RQ14 RQ18
      filt_rst_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      filt_rst_r <= filt_rst_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign dout_rdy = dout_r;
  assign dout_rdy_oe = oe_r;
  assign filter_reset = filt_rst_r;
  assign converter_status = status_r;
  assign operating_mode_select = mode_r[`ASM_MR_MODE_HI:`ASM_MR_MODE_LO]; // RQ17
  assign append_status_enable = mode_r[`ASM_MR_APPEND];
  assign clock_source_select = mode_r[`ASM_MR_CLK_HI:`ASM_MR_CLK_LO];
  assign fast_settle_average_hi = mode_r[`ASM_MR_AVG_HI];
  assign fast_settle_average_lo = mode_r[`ASM_MR_AVG_LO];
  assign third_order_filter_select = mode_r[`ASM_MR_THIRD];
  assign parity_check_enable = mode_r[`ASM_MR_PARITY];
  assign clock_halve_enable = mode_r[`ASM_MR_CLKDIV];
  assign single_cycle_settle = mode_r[`ASM_MR_SINGLE];
  assign notch_sixty_hz_enable = mode_r[`ASM_MR_NOTCH60];
  assign rate_word = mode_r[`ASM_MR_RATE_HI:0];

endmodule

// ==== hw/asm_regs.svh ====
// register codes, field positions, reset values and frame lengths of the status/mode bank
`ifndef ASM_REGS_SVH
`define ASM_REGS_SVH

// ------------------------------------------------------------
// register select codes
// ------------------------------------------------------------
`define ASM_RS_STATUS 3'h0
`define ASM_RS_MODE 3'h1
`define ASM_RS_CONFIG 3'h2
`define ASM_RS_DATA 3'h3
`define ASM_RS_IDENT 3'h4
`define ASM_RS_GPO 3'h5
`define ASM_RS_OFFSET 3'h6
`define ASM_RS_FSCALE 3'h7

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ASM_STATUS_RESET 8'h80
`define ASM_MODE_RESET 24'h080060
`define ASM_MODE_WMASK 24'hFFBFFF

// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define ASM_SR_RDY 7
`define ASM_SR_ERR 6
`define ASM_SR_REFMISS 5
`define ASM_SR_PARITY 4

// ------------------------------------------------------------
// mode fields
// ------------------------------------------------------------
`define ASM_MR_MODE_HI 23
`define ASM_MR_MODE_LO 21
`define ASM_MR_APPEND 20
`define ASM_MR_CLK_HI 19
`define ASM_MR_CLK_LO 18
`define ASM_MR_AVG_HI 17
`define ASM_MR_AVG_LO 16
`define ASM_MR_THIRD 15
`define ASM_MR_PARITY 13
`define ASM_MR_CLKDIV 12
`define ASM_MR_SINGLE 11
`define ASM_MR_NOTCH60 10
`define ASM_MR_RATE_HI 9

// ------------------------------------------------------------
// serial frame lengths in bits
// ------------------------------------------------------------
`define ASM_LEN_NONE 6'h00
`define ASM_LEN_BYTE 6'h08
`define ASM_LEN_WORD 6'h18
`define ASM_LEN_WORD_STATUS 6'h20
`define ASM_CMD_BITS 6'h07

`endif

// ==== hw/asm_pkg.sv ====
// types shared by the status/mode register bank
package asm_pkg;

  // ------------------------------------------------------------
  // serial interface states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ASM_ST_IDLE = 2'b00,
    ASM_ST_CMD = 2'b01,
    ASM_ST_DATA = 2'b10
  } asm_state_t;

endpackage

// ==== hw/asm_pin_sync.sv ====
// two-stage synchroniser for pins arriving from outside the ref_clk domain
`timescale 1ns/1ps

module asm_pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // pins
  input wire logic [W-1:0] pin_in,
  // synchronised levels
  output logic [W-1:0] pin_sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  assign pin_sync = sync_r;

endmodule

// ==== bench/asm_status_mode_checker.sv ====
// assertions on the ports of the status/mode register bank
`timescale 1ns/1ps
module asm_status_mode_checker #(
  parameter int DATA_W = 24
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // pins and core strobes
  input wire logic cs_n,
  input wire logic filter_sync_n,
  input wire logic result_valid,
  input wire logic [DATA_W-1:0] result_data,
  input wire logic result_clamped,
  input wire logic [3:0] result_channel,
  input wire logic update_warn,
  input wire logic low_power_entry,
  input wire logic cal_error,
  input wire logic ref_low,
  input wire logic reference_detect_enable,
  // outputs
  input wire logic filter_reset,
  input wire logic parity_check_enable,
  input wire logic [1:0] clock_source_select,
  input wire logic [9:0] rate_word,
  input wire logic [7:0] converter_status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ----
  // properties
  // ----
  a_status_reset: assert property ($past(srst) |-> converter_status == 8'h80)
    else $error("status reset value wrong");
  a_mode_reset: assert property ($past(srst) |-> {clock_source_select, rate_word} == 12'h860)
    else $error("mode reset value wrong");
  // idle serial side, so no read or write can set ready in the same cycle
  a_result_fresh: assert property ((cs_n && filter_sync_n)[*5] ##0 (result_valid &&
    !update_warn && !low_power_entry) |=> !converter_status[7])
    else $error("ready not cleared by new result");
  a_tag_held: assert property (result_valid |=> converter_status[3:0] == $past(result_channel))
    else $error("channel tag wrong");
  a_err_update: assert property (result_valid && !cal_error |=> converter_status[6] ==
    $past(result_clamped || reference_detect_enable && ref_low))
    else $error("error bit wrong after result");
  a_cal_err: assert property (cal_error |=> converter_status[6])
    else $error("calibration error not flagged");
  a_refmiss_track: assert property (!$past(srst) |->
    converter_status[5] == $past(reference_detect_enable && ref_low))
    else $error("reference flag wrong");
  a_parity_odd: assert property (result_valid && parity_check_enable &&
    !(reference_detect_enable && ref_low) |-> ##2 converter_status[4] == ^$past(result_data, 2))
    else $error("parity bit wrong");
  a_write_ready: assert property (filter_reset |-> converter_status[7])
    else $error("mode write left ready clear");
  a_reset_pulse: assert property (filter_reset |=> !filter_reset)
    else $error("filter reset too long");
  a_mode_on_write: assert property (!$past(srst) &&
    !$stable({clock_source_select, rate_word, parity_check_enable}) |-> filter_reset)
    else $error("mode changed without write");
  a_warn_ready: assert property (update_warn || low_power_entry |=> converter_status[7])
    else $error("ready not set by core event");
  a_sync_ready: assert property ((!filter_sync_n)[*5] |-> converter_status[7])
    else $error("ready not held by sync");
  c_write: cover property (filter_reset);
  c_fresh: cover property (result_valid ##1 !converter_status[7]);
  c_sync: cover property ((!filter_sync_n)[*5]);
endmodule

bind asm_status_mode asm_status_mode_checker #(.DATA_W(DATA_W)) chk (.*);

// ==== bench/asm_host_model.sv ====
// serial host controller model driving the register bank pins
`timescale 1ns/1ps
module asm_host_model (
  // clock
  input wire logic ref_clk,
  // serial pins
  input wire logic dout_rdy,
  output logic sclk,
  output logic din,
  output logic cs_n
);
  // clock idles high, data idles high between frames
  initial begin
    sclk = 1'b1;
    din = 1'b1;
    cs_n = 1'b1;
  end
  // ----
  // frame: command byte then n data bits, msb first
  // ----
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [31:0] wd,
                      output logic [31:0] rd);
    logic [39:0] sh;
    sh = {cmd, wd << (32 - n)};
    rd = '0;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 8 + n; i++) begin
      sclk <= 1'b0;
      din <= sh[39 - i];
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b1;
      // sample late in the high phase, away from the shift
      repeat (3) @(posedge ref_clk);
      if (i >= 8) rd = {rd[30:0], dout_rdy};
      @(posedge ref_clk);
    end
    din <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
  // select without clocking, to watch the ready view
  task automatic sel(input logic on);
    @(posedge ref_clk);
    cs_n <= !on;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule

// ==== bench/asm_status_mode_test.sv ====
// self-checking bench of the status/mode register bank
`timescale 1ns/1ps
`include "asm_regs.svh"
module asm_status_mode_test;
  logic ref_clk, srst, sclk, din, cs_n, filter_sync_n, dout_rdy, dout_rdy_oe;
  logic result_valid, result_clamped, update_warn, low_power_entry, cal_error;
  logic ref_low, reference_detect_enable, filter_reset, append_status_enable;
  logic fast_settle_average_hi, fast_settle_average_lo, third_order_filter_select;
  logic parity_check_enable, clock_halve_enable, single_cycle_settle, notch_sixty_hz_enable;
  logic [2:0] operating_mode_select;
  logic [1:0] clock_source_select;
  logic [9:0] rate_word;
  logic [3:0] result_channel;
  logic [23:0] result_data;
  logic [7:0] converter_status, st;
  logic [31:0] rd, seed, mw;
  int failures, checked;
  wire [23:0] mode_out = {operating_mode_select, append_status_enable, clock_source_select,
    fast_settle_average_hi, fast_settle_average_lo, third_order_filter_select, 1'b0,
    parity_check_enable, clock_halve_enable, single_cycle_settle, notch_sixty_hz_enable,
    rate_word};

  asm_status_mode dut (.*);
  asm_host_model host (.*);

  // ----
  // helpers
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // missing reference stores all ones, so parity follows that word
  function automatic logic [7:0] stat(input logic [23:0] d, input logic [3:0] ch,
                                      input logic cl);
    logic nr;
    nr = reference_detect_enable & ref_low;
    return {1'b0, cl | nr, nr, parity_check_enable & ^(nr ? 24'hFFFFFF : d), ch};
  endfunction
  task automatic result(input logic [23:0] d, input logic [3:0] ch, input logic cl);
    @(posedge ref_clk);
    {result_valid, result_clamped, result_channel, result_data} <= {1'b1, cl, ch, d};
    @(posedge ref_clk);
    result_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    st = stat(d, ch, cl);
    check(converter_status, st);
  endtask
  task automatic pulse(input int k);
    @(posedge ref_clk);
    {update_warn, low_power_entry, cal_error} <= 3'(1 << k);
    @(posedge ref_clk);
    {update_warn, low_power_entry, cal_error} <= 3'h0;
    repeat (3) @(posedge ref_clk);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #2000000;
    failures++;
    tally_and_finish();
  end

  // ----
  // main sequence
  // ----
  initial begin
    {srst, filter_sync_n, reference_detect_enable} = 3'h7;
    {result_valid, result_clamped, update_warn, low_power_entry, cal_error, ref_low} = '0;
    result_data = '0;
    result_channel = '0;
    failures = 0;
    checked = 0;
    seed = 32'h7700;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check(converter_status, `ASM_STATUS_RESET);
    check(mode_out, `ASM_MODE_RESET);
    host.xfer(8'h40, 8, '0, rd);
    check(rd, `ASM_STATUS_RESET);
    host.xfer(8'h48, 24, '0, rd);
    check(rd, `ASM_MODE_RESET);
    // random mode words; last one turns on parity with status append
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      mw = seed & 32'hFFFFFF | (i == 3 ? 32'h102000 : 32'h0);
      result(seed[31:8], seed[3:0], seed[4]);
      host.xfer(8'h08, 24, mw, rd);
      check(converter_status[7], 1'b1);
      check(mode_out, mw & `ASM_MODE_WMASK);
      host.xfer(8'h48, 24, '0, rd);
      check(rd, mw & `ASM_MODE_WMASK);
    end
    // clamped result, then missing reference, each read with status
    // third pass: low reference with detection off must not clamp
    for (int j = 0; j < 3; j++) begin
      {reference_detect_enable, ref_low} <= (j == 2) ? 2'b01 : {1'b1, j[0]};
      seed = xs(seed);
      result(seed[23:0], seed[27:24], j == 0);
      host.xfer(8'h58, 32, '0, rd);
      check(rd, {(j == 1) ? 24'hFFFFFF : seed[23:0], st});
      check(converter_status[7], 1'b1);
    end
    {reference_detect_enable, ref_low} <= 2'b10;
    for (int k = 0; k < 3; k++) begin
      result(24'h000001, 4'hF, 1'b0);
      pulse(k);
      check(converter_status[7:6], (k == 0) ? 2'b01 : 2'b10);
    end
    result(24'hFFFFFE, 4'h7, 1'b0);
    host.sel(1'b1);
    check({dout_rdy_oe, dout_rdy}, 2'b10);
    filter_sync_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check({converter_status[7], dout_rdy}, 2'b11);
    filter_sync_n <= 1'b1;
    host.sel(1'b0);
    tally_and_finish();
  end
endmodule
